// ### tb.sv
// Self-checking testbench of the chained temperature sensor core
`timescale 1ns/1ps
module tb;
  localparam int unsigned BC = 8;
  localparam int unsigned TMO = 200;
  localparam logic [3:0] ID = 4'h5;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] dev_id = ID;
  logic [7:0] adc_temp = 8'h19;
  logic rx_in;
  logic tx_out;
  logic alert_hold;
  logic [7:0] v;
  int failures = 0;
  int n_tests = 0;

  // Clock of 100 ns
  always #50 clk = ~clk;

  // Device and host
  tdcs_core #(.BIT_CYC(BC), .TMO_CYC(TMO), .CONV_CYC(300), .PER0_CYC(2000),
    .PER1_CYC(1200), .PER2_CYC(800), .PER3_CYC(600)) dut_u (.clk(clk), .nrst(nrst),
    .rx_in(rx_in), .tx_out(tx_out), .dev_id(dev_id), .adc_temp(adc_temp),
    .alert_hold(alert_hold));
  tdcs_host_model #(.BC(BC)) host_u (.clk(clk), .host_tx(rx_in), .host_rx(tx_out));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one byte
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  // Read one register and compare
  task automatic rc(input string nm, input logic [1:0] p, input logic [7:0] e);
    host_u.rd(ID, p, v);
    chk8(nm, e, v);
  endtask : rc

  // New converter value on a rising edge
  task automatic set_adc(input logic [7:0] t);
    @(posedge clk);
    adc_temp <= t;
  endtask : set_adc

  // Verdict and end of run
  task automatic close_out();
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  // Values straight after reset
  task automatic t_reset_vals();
    rc("temp", tdcs_pkg::PTR_TEMP, 8'h00);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h02);
    rc("thigh", tdcs_pkg::PTR_THI, 8'h3C);
    rc("tlow", tdcs_pkg::PTR_TLO, 8'hF6);
  endtask : t_reset_vals

  // Writes by ID, read-only temperature
  task automatic t_write();
    host_u.wr(ID, tdcs_pkg::PTR_THI, 8'h40);
    rc("thigh", tdcs_pkg::PTR_THI, 8'h40);
    host_u.wr(4'hA, tdcs_pkg::PTR_THI, 8'h11);
    rc("thigh", tdcs_pkg::PTR_THI, 8'h40);
    dev_id <= 4'hA;
    host_u.rd(4'hA, tdcs_pkg::PTR_THI, v);
    chk8("thigh_new_id", 8'h40, v);
    dev_id <= ID;
    host_u.wr(ID, tdcs_pkg::PTR_TEMP, 8'h77);
    rc("temp", tdcs_pkg::PTR_TEMP, 8'h19);
  endtask : t_write

  // Signed limit flags, unlatched
  task automatic t_flags();
    host_u.wr(ID, tdcs_pkg::PTR_CFG, 8'h62);
    set_adc(8'hF0);
    repeat (700) @(posedge clk);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h6A);
    host_u.wr(ID, tdcs_pkg::PTR_CFG, 8'h42);
    set_adc(8'h50);
    repeat (900) @(posedge clk);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h52);
  endtask : t_flags

  // Shutdown then a single conversion
  task automatic t_oneshot();
    set_adc(8'h19);
    repeat (900) @(posedge clk);
    host_u.wr(ID, tdcs_pkg::PTR_CFG, 8'h60);
    repeat (700) @(posedge clk);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h60);
    set_adc(8'h32);
    host_u.wr(ID, tdcs_pkg::PTR_CFG, 8'h61);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h61);
    repeat (400) @(posedge clk);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h60);
    rc("temp", tdcs_pkg::PTR_TEMP, 8'h32);
  endtask : t_oneshot

  // Alert raised, held low, then cleared
  task automatic t_alert();
    set_adc(8'h50);
    host_u.wr(ID, tdcs_pkg::PTR_CFG, 8'hA2);
    for (int i = 0; i < 3000 && alert_hold !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    chk8("alert", 8'h01, {7'h00, alert_hold});
    chk8("line", 8'h00, {7'h00, tx_out});
    host_u.rxq.delete();
    host_u.iclr();
    for (int i = 0; i < 200 && alert_hold !== 1'b0; i++) @(posedge clk);
    chk8("alert", 8'h00, {7'h00, alert_hold});
    for (int i = 0; i < 400 && host_u.rxq.size() < 2; i++) @(posedge clk);
    repeat (2 * BC) @(posedge clk);
    v = (host_u.rxq.size() > 0) ? host_u.rxq[$] : 8'hXX;
    chk8("fwd", tdcs_pkg::CMD_GICLR, v);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h36);
  endtask : t_alert

  // Global reset restores temperature, upper limit and configuration
  task automatic t_grst();
    set_adc(8'h19);
    host_u.wr(ID, tdcs_pkg::PTR_THI, 8'h20);
    host_u.grst();
    rc("temp", tdcs_pkg::PTR_TEMP, 8'h00);
    rc("thigh", tdcs_pkg::PTR_THI, 8'h3C);
    rc("cfg", tdcs_pkg::PTR_CFG, 8'h02);
  endtask : t_grst

  // Gap too long drops the data byte
  task automatic t_tmo();
    host_u.send_byte(tdcs_pkg::CAL_BYTE);
    host_u.send_byte({1'b0, ID, tdcs_pkg::PTR_THI, 1'b0});
    repeat (TMO + 50) @(posedge clk);
    host_u.send_byte(8'h20);
    rc("thigh", tdcs_pkg::PTR_THI, 8'h3C);
  endtask : t_tmo

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    t_write();
    t_flags();
    t_oneshot();
    t_alert();
    t_grst();
    t_tmo();
    close_out();
  end

  // Watchdog
  initial begin
    #6_000_000;
    failures++;
    close_out();
  end
endmodule : tb

// ### tdcs_core.sv
// Command, register and conversion logic of the chained temperature sensor
`timescale 1ns/1ps
module tdcs_core #(
  parameter int unsigned BIT_CYC = tdcs_pkg::BIT_CYC,
  parameter int unsigned TMO_CYC = tdcs_pkg::TMO_CYC,
  parameter int unsigned CONV_CYC = tdcs_pkg::CONV_CYC,
  parameter int unsigned PER0_CYC = tdcs_pkg::PER0_CYC,
  parameter int unsigned PER1_CYC = tdcs_pkg::PER1_CYC,
  parameter int unsigned PER2_CYC = tdcs_pkg::PER2_CYC,
  parameter int unsigned PER3_CYC = tdcs_pkg::PER3_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial chain
  input wire logic rx_in,
  output logic tx_out,
  // Sensor side
  input wire logic [3:0] dev_id,
  input wire logic [7:0] adc_temp,
  // Status
  output logic alert_hold
);
  typedef enum logic [1:0] {P_CAL = 2'b00, P_CMD = 2'b01, P_DATA = 2'b11,
                            P_SEND = 2'b10} tdcs_pst_e;
  typedef enum logic [1:0] {C_OFF = 2'b00, C_RUN = 2'b01, C_WAIT = 2'b11} tdcs_cst_e;

  tdcs_ser_if ser ();
  tdcs_pst_e pst_r;
  tdcs_cst_e cst_r;
  logic match_r, rw_r, pass_r, alert_r, clr_seq_r, tx_out_r;
  logic [1:0] ptr_r;
  logic int_en_r, fh_r, fl_r, latch_r;
  logic [1:0] rate_r, mode_r;
  logic [7:0] thi_r, tlo_r, temp_r;
  logic [31:0] ccnt_r, tmo_r, idle_r, per_sel;
  logic [7:0] rxb, cfg_val, rd_val;
  logic cmd_take, grst, giclr, hit, cfg_rd, wr_take, conv_done, over, under, tmo_hit;

  tdcs_uart #(.BIT_CYC(BIT_CYC)) u_uart (
    .clk(clk),
    .nrst(nrst),
    .rx_in(rx_in),
    .ser(ser.uart)
  );

  ////////////////////////////////////////////////////////////////
  // Command decode
  always_comb begin
    rxb = ser.rx_byte;
    cmd_take = ser.rx_valid && pst_r == P_CMD;
    grst = cmd_take && rxb == tdcs_pkg::CMD_GRST;
    giclr = cmd_take && rxb == tdcs_pkg::CMD_GICLR;
    hit = cmd_take && !rxb[7] && rxb[6:3] == dev_id;
    cfg_rd = hit && rxb[0] && rxb[2:1] == tdcs_pkg::PTR_CFG;
    wr_take = ser.rx_valid && pst_r == P_DATA && match_r && !rw_r;
    tmo_hit = (pst_r == P_CMD || pst_r == P_DATA) && tmo_r >= TMO_CYC - 1;
    conv_done = cst_r == C_RUN && ccnt_r >= CONV_CYC - 1;
    over = $signed(adc_temp) > $signed(thi_r);
    under = $signed(adc_temp) < $signed(tlo_r);
    cfg_val = {int_en_r, rate_r, fh_r, fl_r, latch_r, mode_r};
  end

  // Register read select and conversion period
  always_comb begin
    case (rxb[2:1])
      tdcs_pkg::PTR_TEMP: rd_val = temp_r;
      tdcs_pkg::PTR_CFG: rd_val = cfg_val;
      tdcs_pkg::PTR_TLO: rd_val = tlo_r;
      default: rd_val = thi_r;
    endcase
    case (rate_r)
      2'h0: per_sel = PER0_CYC;
      2'h1: per_sel = PER1_CYC;
      2'h2: per_sel = PER2_CYC;
      default: per_sel = PER3_CYC;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_ff @(posedge clk) begin
    ser.tx_go <= 1'b0;
    if (!nrst) begin
      pst_r <= P_CAL;
      match_r <= 1'b0;
      rw_r <= 1'b0;
      ptr_r <= 2'h0;
      pass_r <= 1'b1;
      alert_r <= 1'b0;
      clr_seq_r <= 1'b0;
      ser.tx_byte <= 8'h00;
    end else if (tmo_hit) begin
      pst_r <= P_CAL;
    end else begin
      if (int_en_r && (fh_r || fl_r) && idle_r >= TMO_CYC) begin
        alert_r <= 1'b1;
        pass_r <= 1'b0;
      end
      case (pst_r)
        P_CAL: if (ser.rx_valid && rxb == tdcs_pkg::CAL_BYTE) pst_r <= P_CMD;
        P_CMD: if (ser.rx_valid) begin
          match_r <= hit;
          rw_r <= rxb[0];
          ptr_r <= rxb[2:1];
          pst_r <= rxb[7] ? P_CAL : P_DATA;
          if (grst) begin
            pass_r <= 1'b1;
            alert_r <= 1'b0;
          end
          if (giclr && alert_r) begin
            alert_r <= 1'b0;
            clr_seq_r <= 1'b1;
            ser.tx_go <= 1'b1;
            ser.tx_byte <= tdcs_pkg::CAL_BYTE;
            pst_r <= P_SEND;
          end
          if (hit && rxb[0]) begin
            pass_r <= 1'b0;
            ser.tx_go <= 1'b1;
            ser.tx_byte <= rd_val;
            pst_r <= P_SEND;
          end
        end
        P_DATA: if (ser.rx_valid) pst_r <= P_CAL;
        P_SEND: if (ser.tx_done) begin
          if (clr_seq_r) begin
            clr_seq_r <= 1'b0;
            ser.tx_go <= 1'b1;
            ser.tx_byte <= tdcs_pkg::CMD_GICLR;
          end else begin
            pass_r <= 1'b1;
            pst_r <= P_CAL;
          end
        end
        default: pst_r <= P_CAL;
      endcase
    end
  end

  // Inter-byte timeout, restarted by every byte in either direction
  always_ff @(posedge clk) begin
    if (!nrst || ser.rx_valid || ser.tx_done || pst_r == P_CAL || pst_r == P_SEND) begin
      tmo_r <= 32'h00000000;
    end else begin
      tmo_r <= tmo_r + 32'h00000001;
    end
  end

  // Idle-high line timer for the alert
  always_ff @(posedge clk) begin
    if (!nrst || !rx_in || pst_r != P_CAL || ser.tx_busy) begin
      idle_r <= 32'h00000000;
    end else if (idle_r < TMO_CYC) begin
      idle_r <= idle_r + 32'h00000001;
    end
  end

  // Line driver: alert low, own byte, pass-through, or idle high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_out_r <= 1'b1;
    end else if (alert_r) begin
      tx_out_r <= 1'b0;
    end else if (ser.tx_busy) begin
      tx_out_r <= ser.tx_bit;
    end else begin
      tx_out_r <= pass_r ? rx_in : 1'b1;
    end
  end

  assign tx_out = tx_out_r;
  assign alert_hold = alert_r;

  ////////////////////////////////////////////////////////////////
  // Configuration, limits and flags
  always_ff @(posedge clk) begin
    if (!nrst || grst) begin
      int_en_r <= tdcs_pkg::CFG_RST[tdcs_pkg::CFG_INT_EN];
      rate_r <= tdcs_pkg::CFG_RST[tdcs_pkg::CFG_RATE_HI -: 2];
      latch_r <= tdcs_pkg::CFG_RST[tdcs_pkg::CFG_LATCH];
      mode_r <= tdcs_pkg::CFG_RST[tdcs_pkg::CFG_MODE_HI -: 2];
      fh_r <= 1'b0;
      fl_r <= 1'b0;
      thi_r <= tdcs_pkg::THI_RST;
      tlo_r <= tdcs_pkg::TLO_RST;
    end else begin
      if (giclr) int_en_r <= 1'b0;
      if (wr_take && ptr_r == tdcs_pkg::PTR_CFG) begin
        int_en_r <= rxb[tdcs_pkg::CFG_INT_EN];
        rate_r <= rxb[tdcs_pkg::CFG_RATE_HI -: 2];
        latch_r <= rxb[tdcs_pkg::CFG_LATCH] | rxb[tdcs_pkg::CFG_INT_EN];
        mode_r <= rxb[tdcs_pkg::CFG_MODE_HI -: 2];
      end else if (conv_done && mode_r == tdcs_pkg::MODE_ONE) begin
        mode_r <= tdcs_pkg::MODE_OFF;
      end
      if (wr_take && ptr_r == tdcs_pkg::PTR_THI) thi_r <= rxb;
      if (wr_take && ptr_r == tdcs_pkg::PTR_TLO) tlo_r <= rxb;
      if (conv_done) begin
        fh_r <= over | (fh_r & latch_r & !cfg_rd);
        fl_r <= under | (fl_r & latch_r & !cfg_rd);
      end else if (cfg_rd) begin
        fh_r <= 1'b0;
        fl_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Conversion sequencer and result register
  always_ff @(posedge clk) begin
    if (!nrst || grst) begin
      cst_r <= C_RUN;
      ccnt_r <= 32'h00000000;
      temp_r <= tdcs_pkg::TEMP_RST;
    end else begin
      case (cst_r)
        C_RUN: if (conv_done) begin
          temp_r <= adc_temp;
          ccnt_r <= 32'h00000000;
          cst_r <= mode_r[1] ? C_WAIT : C_OFF;
        end else begin
          ccnt_r <= ccnt_r + 32'h00000001;
        end
        C_WAIT: if (!mode_r[1]) begin
          cst_r <= C_OFF;
        end else if (ccnt_r + CONV_CYC + 1 >= per_sel) begin
          cst_r <= C_RUN;
          ccnt_r <= 32'h00000000;
        end else begin
          ccnt_r <= ccnt_r + 32'h00000001;
        end
        C_OFF: if (mode_r != tdcs_pkg::MODE_OFF) begin
          cst_r <= C_RUN;
          ccnt_r <= 32'h00000000;
        end
        default: cst_r <= C_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  sequence s_oneshot_end;
    conv_done && mode_r == tdcs_pkg::MODE_ONE && !wr_take && !grst;
  endsequence
  property p_grst;
    @(posedge clk) disable iff (!nrst) grst |=> cfg_val == tdcs_pkg::CFG_RST && pass_r;
  endproperty
  a_grst: assert property (p_grst) else $error("global reset left state");
  property p_rd;
    @(posedge clk) disable iff (!nrst) hit && rxb[0] |=> !pass_r && ser.tx_go ##1 ser.tx_busy;
  endproperty
  a_rd: assert property (p_rd) else $error("read did not break and send");
  property p_temp0;
    @(posedge clk) disable iff (!nrst) grst |=> temp_r == 8'h00 && cst_r == C_RUN;
  endproperty
  a_temp0: assert property (p_temp0) else $error("temperature not cleared");
  property p_cfgrst;
    @(posedge clk) !nrst |=> cfg_val == tdcs_pkg::CFG_RST;
  endproperty
  a_cfgrst: assert property (p_cfgrst) else $error("bad configuration reset");
  property p_oneshot;
    @(posedge clk) disable iff (!nrst) s_oneshot_end |=> mode_r == 2'h0 ##1 cst_r == C_OFF;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");
  property p_alert;
    @(posedge clk) disable iff (!nrst) $rose(alert_r) |=> !tx_out_r && !pass_r;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driving low");
  property p_latch;
    @(posedge clk) disable iff (!nrst) wr_take && ptr_r == tdcs_pkg::PTR_CFG && rxb[7]
      && !grst |=> latch_r && int_en_r;
  endproperty
  a_latch: assert property (p_latch) else $error("latch not set by enable");
  property p_tmo;
    @(posedge clk) disable iff (!nrst) tmo_hit |=> pst_r == P_CAL;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout did not reset");
  property p_over;
    @(posedge clk) disable iff (!nrst) conv_done && over && !grst |=> fh_r;
  endproperty
  a_over: assert property (p_over) else $error("over flag not set");
  sequence s_pass_idle;
    pass_r && !alert_r && !ser.tx_busy;
  endsequence
  property p_pass;
    @(posedge clk) disable iff (!nrst) s_pass_idle |=> tx_out_r == $past(rx_in);
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through copy wrong");
  property p_flagclr;
    @(posedge clk) disable iff (!nrst) cfg_rd && !conv_done |=> !fh_r && !fl_r;
  endproperty
  a_flagclr: assert property (p_flagclr) else $error("flags not cleared by read");
  property p_unlatch;
    @(posedge clk) disable iff (!nrst) conv_done && !latch_r && !over && !under
      |=> !fh_r && !fl_r;
  endproperty
  a_unlatch: assert property (p_unlatch) else $error("unlatched flags kept");
  property p_giclr;
    @(posedge clk) disable iff (!nrst) giclr && !tmo_hit |=> !int_en_r && !alert_r;
  endproperty
  a_giclr: assert property (p_giclr) else $error("interrupt clear ignored");
  property p_alert_keep;
    @(posedge clk) disable iff (!nrst) alert_r && !cmd_take |=> alert_r;
  endproperty
  a_alert_keep: assert property (p_alert_keep) else $error("alert dropped early");
  property p_shutdown;
    @(posedge clk) disable iff (!nrst) conv_done && mode_r == tdcs_pkg::MODE_OFF && !grst
      |=> cst_r == C_OFF;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown after conversion");
  property p_oneshot_go;
    @(posedge clk) disable iff (!nrst) cst_r == C_OFF && mode_r == tdcs_pkg::MODE_ONE
      |=> cst_r == C_RUN;
  endproperty
  a_oneshot_go: assert property (p_oneshot_go) else $error("one-shot did not start");
  property p_result;
    @(posedge clk) disable iff (!nrst) conv_done && !grst |=> temp_r == $past(adc_temp);
  endproperty
  a_result: assert property (p_result) else $error("result not loaded");
  property p_wrthi;
    @(posedge clk) disable iff (!nrst) wr_take && ptr_r == tdcs_pkg::PTR_THI
      |=> thi_r == $past(rxb);
  endproperty
  a_wrthi: assert property (p_wrthi) else $error("upper limit write lost");
endmodule : tdcs_core

// ### tdcs_host_model.sv
// Host controller model that drives and listens on the serial chain
`timescale 1ns/1ps
module tdcs_host_model #(
  parameter int unsigned BC = 8
) (
  // Clock
  input wire logic clk,
  // Chain wires
  output logic host_tx,
  input wire logic host_rx
);
  logic [7:0] rxq[$];
  logic [7:0] b;

  // Line idles high
  initial begin
    host_tx = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One framed byte, start low, LSB first, stop high
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_tx <= fr[i];
      repeat (BC) @(posedge clk);
    end
  endtask : send_byte

  // Individual write with its data byte
  task automatic wr(input logic [3:0] id, input logic [1:0] ptr, input logic [7:0] d);
    send_byte(tdcs_pkg::CAL_BYTE);
    send_byte({1'b0, id, ptr, 1'b0});
    send_byte(d);
  endtask : wr

  // Individual read, third byte seen back is the answer
  task automatic rd(input logic [3:0] id, input logic [1:0] ptr, output logic [7:0] d);
    rxq.delete();
    send_byte(tdcs_pkg::CAL_BYTE);
    send_byte({1'b0, id, ptr, 1'b1});
    for (int i = 0; i < 400 && rxq.size() < 3; i++) @(posedge clk);
    d = (rxq.size() > 2) ? rxq[2] : 8'hXX;
    repeat (2 * BC) @(posedge clk);
  endtask : rd

  // Global reset, sent up to four times until it comes back round
  task automatic grst();
    for (int n = 0; n < 4; n++) begin
      rxq.delete();
      send_byte(tdcs_pkg::CAL_BYTE);
      send_byte(tdcs_pkg::CMD_GRST);
      repeat (2 * BC) @(posedge clk);
      if (rxq.size() > 1 && rxq[1] === tdcs_pkg::CMD_GRST) break;
    end
  endtask : grst

  // Calibration, then clear only when the return side is low
  task automatic iclr();
    send_byte(tdcs_pkg::CAL_BYTE);
    if (host_rx === 1'b0) send_byte(tdcs_pkg::CMD_GICLR);
  endtask : iclr

  ////////////////////////////////////////////////////////////////////////////////
  // Collect each well framed byte on the return side
  always begin
    @(posedge clk);
    if (host_rx === 1'b0) begin
      repeat (BC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BC) @(posedge clk);
        b[i] = host_rx;
      end
      repeat (BC) @(posedge clk);
      if (host_rx === 1'b1) rxq.push_back(b);
      while (host_rx !== 1'b1) @(posedge clk);
    end
  end
endmodule : tdcs_host_model

// ### tdcs_pkg.sv
// Shared constants of the daisy-chain temperature sensor core
package tdcs_pkg;
  // Clock and times
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TMO_MS = 28;
  localparam int unsigned CONV_MS = 26;
  localparam int unsigned TMO_CYC = CLK_HZ / 1000 * TMO_MS;
  localparam int unsigned CONV_CYC = CLK_HZ / 1000 * CONV_MS;
  // Conversion periods per rate select value, in ms
  localparam int unsigned PER0_MS = 4000;
  localparam int unsigned PER1_MS = 1000;
  localparam int unsigned PER2_MS = 250;
  localparam int unsigned PER3_MS = 125;
  localparam int unsigned PER0_CYC = CLK_HZ / 1000 * PER0_MS;
  localparam int unsigned PER1_CYC = CLK_HZ / 1000 * PER1_MS;
  localparam int unsigned PER2_CYC = CLK_HZ / 1000 * PER2_MS;
  localparam int unsigned PER3_CYC = CLK_HZ / 1000 * PER3_MS;
  localparam int unsigned BIT_CYC = 1042;
  // Command bytes
  localparam logic [7:0] CAL_BYTE = 8'h55;
  localparam logic [7:0] CMD_GRST = 8'hB4;
  localparam logic [7:0] CMD_GICLR = 8'hA9;
  // Register pointer codes
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_TLO = 2'h2;
  localparam logic [1:0] PTR_THI = 2'h3;
  // Configuration field positions
  localparam int CFG_INT_EN = 7;
  localparam int CFG_RATE_HI = 6;
  localparam int CFG_LATCH = 2;
  localparam int CFG_MODE_HI = 1;
  // Reset values and conversion mode codes
  localparam logic [7:0] CFG_RST = 8'h02;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] THI_RST = 8'h3C;
  localparam logic [7:0] TLO_RST = 8'hF6;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
endpackage : tdcs_pkg

// ### tdcs_ser_if.sv
// Byte-level link between the protocol core and the serial engine
`timescale 1ns/1ps
interface tdcs_ser_if;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic tx_go;
  logic [7:0] tx_byte;
  logic tx_busy;
  logic tx_done;
  logic tx_bit;
  modport core (input rx_valid, rx_byte, tx_busy, tx_done, tx_bit, output tx_go, tx_byte);
  modport uart (output rx_valid, rx_byte, tx_busy, tx_done, tx_bit, input tx_go, tx_byte);
endinterface : tdcs_ser_if

// ### tdcs_uart.sv
// Serial byte receiver and transmitter, LSB first, start and stop framed
`timescale 1ns/1ps
module tdcs_uart #(
  parameter int unsigned BIT_CYC = tdcs_pkg::BIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial input
  input wire logic rx_in,
  // Byte side
  tdcs_ser_if.uart ser
);
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
                            RX_STOP = 2'b10} tdcs_rx_e;
  localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYC / 2 - 1);
  tdcs_rx_e rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_n_r;
  logic [15:0] tx_cnt_r;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_n_r;

  ////////////////////////////////////////////////////////////////
  // Receiver, samples each bit at its middle
  always_ff @(posedge clk) begin
    ser.rx_valid <= 1'b0;
    if (!nrst) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_sh_r <= 8'h00;
      rx_n_r <= 3'h0;
      ser.rx_byte <= 8'h00;
    end else if (rx_st_r != RX_IDLE && rx_cnt_r != 16'h0000) begin
      rx_cnt_r <= rx_cnt_r - 16'h0001;
    end else begin
      case (rx_st_r)
        RX_IDLE: if (!rx_in) begin
          rx_st_r <= RX_START;
          rx_cnt_r <= HALF;
        end
        RX_START: begin
          rx_st_r <= rx_in ? RX_IDLE : RX_DATA; // Glitch rejection
          rx_cnt_r <= FULL;
          rx_n_r <= 3'h0;
        end
        RX_DATA: begin
          rx_sh_r <= {rx_in, rx_sh_r[7:1]};
          rx_cnt_r <= FULL;
          rx_n_r <= rx_n_r + 3'h1;
          if (rx_n_r == 3'h7) rx_st_r <= RX_STOP;
        end
        RX_STOP: begin
          rx_st_r <= RX_IDLE;
          ser.rx_valid <= rx_in; // Framing error drops the byte
          ser.rx_byte <= rx_sh_r;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Transmitter, start bit, eight data bits, stop bit
  always_ff @(posedge clk) begin
    ser.tx_done <= 1'b0;
    if (!nrst) begin
      tx_sh_r <= 10'h3FF;
      tx_cnt_r <= 16'h0000;
      tx_n_r <= 4'h0;
      ser.tx_busy <= 1'b0;
    end else if (!ser.tx_busy) begin
      if (ser.tx_go) begin
        tx_sh_r <= {1'b1, ser.tx_byte, 1'b0};
        tx_cnt_r <= FULL;
        tx_n_r <= 4'h0;
        ser.tx_busy <= 1'b1;
      end
    end else if (tx_cnt_r != 16'h0000) begin
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    end else begin
      tx_cnt_r <= FULL;
      tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      tx_n_r <= tx_n_r + 4'h1;
      if (tx_n_r == 4'h9) begin
        ser.tx_busy <= 1'b0;
        ser.tx_done <= 1'b1;
      end
    end
  end

  assign ser.tx_bit = tx_sh_r[0];
endmodule : tdcs_uart
